/* hdl/ecpd_consts.svh */
// Purpose: constants for the encoder count pulse divider
// Assumes: 50 MHz system clock, 32-bit register words
// Notes: offsets are byte addresses on the register bus
`ifndef ECPD_CONSTS_SVH
`define ECPD_CONSTS_SVH
`define ECPD_CLK_HZ 50000000
`define ECPD_PULSE_NS 13000
// least width rounds up to whole cycles
`define ECPD_PULSE_CYC ((`ECPD_PULSE_NS * (`ECPD_CLK_HZ / 1000000) + 999) / 1000)
`define ECPD_OFF_CTRL 8'h00
`define ECPD_OFF_START 8'h04
`define ECPD_OFF_STOP 8'h08
`define ECPD_OFF_PERIOD 8'h0c
`define ECPD_OFF_STATUS 8'h10
`define ECPD_OFF_POS 8'h14
`define ECPD_CTRL_EN_BIT 0
`define ECPD_CTRL_DIR_BIT 1
`define ECPD_PERIOD_RST 16'h0001
`endif

/* hdl/ecpd_pkg.sv */
// Purpose: types for the encoder count pulse divider
// Assumes: nothing beyond the constants header
// Notes: all state of the core but the assertion counter hi_cnt is one packed struct
package ecpd_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_DONE} ecpd_mode_t;
   typedef struct packed {
      logic enable;
      logic reverse;
      logic [31:0] start_pos;
      logic [31:0] stop_pos;
      logic [15:0] period;
   } ecpd_cfg_t;
   typedef struct packed {
      ecpd_cfg_t cfg;
      ecpd_mode_t mode;
      logic [31:0] pos_last;
      logic pos_valid;
      logic [15:0] accum;
      logic pending;
      logic [15:0] width_cnt;
      logic pulse;
      logic [31:0] pulse_count;
      logic hsel_d;
      logic hwrite_d;
      logic [7:0] haddr_d;
      logic [31:0] hrdata;
      logic pin_meta;
      logic pin_sync;
   } ecpd_state_t;
endpackage

/* hdl/ecpd_core.sv */
// Purpose: encoder count pulse divider with an AHB-Lite register slave
// Assumes: encoder position counter is on clk_sys_i; open-collector output pin
// Notes: oe low means the pin is pulled low (pulse active)
// Notes: the encoder counter may move by at most one count per clock
// Notes: the register slave never waits, so hreadyout is tied high
`timescale 1ns/100ps
`include "ecpd_consts.svh"

module ecpd_core
   import ecpd_pkg::*;
#(
   parameter int POS_W = 32
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [31:0] enc_pos_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic div_pin_i,
   output logic div_pin_o,
   output logic div_pin_oe_b_o,
   output logic div_pulse_o
);

   localparam logic [15:0] PULSE_CYC = 16'(`ECPD_PULSE_CYC);

   ecpd_state_t st_reg;
   ecpd_state_t st_next;

   logic fwd_step;
   logic rev_step;
   logic dir_step;
   logic at_start;
   logic at_stop;
   logic req;
   logic wr_go;

   ////////////////////////////////////////////////////////////////////////////
   // combinational next state
   always_comb begin
      st_next = st_reg;
      fwd_step = st_reg.pos_valid && ($signed(enc_pos_i - st_reg.pos_last) > 0);
      rev_step = st_reg.pos_valid && ($signed(enc_pos_i - st_reg.pos_last) < 0);
      dir_step = st_reg.cfg.reverse ? rev_step : fwd_step;
      at_start = (enc_pos_i == st_reg.cfg.start_pos);
      at_stop = (enc_pos_i == st_reg.cfg.stop_pos);
      req = 1'b0;
      wr_go = st_reg.hsel_d && st_reg.hwrite_d;

      // position tracking; one count per cycle at most is assumed
      st_next.pos_last = enc_pos_i;
      st_next.pos_valid = 1'b1;

      // mode sequence
      case (st_reg.mode)
         ST_IDLE: begin
            if (st_reg.cfg.enable) begin
               st_next.mode = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (at_start) begin
               st_next.mode = ST_RUN;
               st_next.accum = 16'h0000;
            end
         end
         ST_RUN: begin
            if (at_stop) begin
               st_next.mode = ST_DONE;
            end else if (dir_step) begin
               if (st_reg.accum + 16'h0001 >= st_reg.cfg.period) begin
                  st_next.accum = 16'h0000;
                  req = 1'b1;
               end else begin
                  st_next.accum = st_reg.accum + 16'h0001;
               end
            end
         end
         ST_DONE: begin
            // stays stopped until re-enabled
         end
         default: begin
            st_next.mode = ST_IDLE;
         end
      endcase
      if (!st_reg.cfg.enable) begin
         st_next.mode = ST_IDLE;
         st_next.pending = 1'b0;
      end

      // pulse timer; a request during a pulse is held, not lost
      // a request while disabled is dropped, else it would fire on re-enable
      if (req && st_reg.cfg.enable) begin
         st_next.pending = 1'b1;
      end
      if (st_reg.pulse) begin
         if (st_reg.width_cnt == PULSE_CYC - 16'h0001) begin
            st_next.pulse = 1'b0;
            st_next.width_cnt = 16'h0000;
         end else begin
            st_next.width_cnt = st_reg.width_cnt + 16'h0001;
         end
      end else if (st_reg.pending && st_reg.cfg.enable) begin
         st_next.pulse = 1'b1;
         st_next.pending = req;
         st_next.width_cnt = 16'h0000;
         st_next.pulse_count = st_reg.pulse_count + 32'h0000_0001;
      end

      // pin readback synchroniser
      st_next.pin_meta = div_pin_i;
      st_next.pin_sync = st_reg.pin_meta;

      // ahb address phase capture
      if (hready_i) begin
         st_next.hsel_d = hsel_i && htrans_i[1] && (hsize_i == 3'b010);
         st_next.hwrite_d = hwrite_i;
         st_next.haddr_d = haddr_i[7:0];
      end
      // data phase write; period zero is forced to one
      if (wr_go) begin
         case (st_reg.haddr_d)
            `ECPD_OFF_CTRL: begin
               st_next.cfg.enable = hwdata_i[`ECPD_CTRL_EN_BIT];
               st_next.cfg.reverse = hwdata_i[`ECPD_CTRL_DIR_BIT];
            end
            `ECPD_OFF_START: st_next.cfg.start_pos = hwdata_i;
            `ECPD_OFF_STOP: st_next.cfg.stop_pos = hwdata_i;
            `ECPD_OFF_PERIOD: begin
               st_next.cfg.period = (hwdata_i[15:0] == 16'h0000) ?
                  `ECPD_PERIOD_RST : hwdata_i[15:0];
            end
            default: begin
            end
         endcase
      end
      // read data registered in the address phase
      st_next.hrdata = 32'h0000_0000;
      if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
         case (haddr_i[7:0])
            `ECPD_OFF_CTRL: st_next.hrdata = {30'h0, st_reg.cfg.reverse, st_reg.cfg.enable};
            `ECPD_OFF_START: st_next.hrdata = st_reg.cfg.start_pos;
            `ECPD_OFF_STOP: st_next.hrdata = st_reg.cfg.stop_pos;
            `ECPD_OFF_PERIOD: st_next.hrdata = {16'h0, st_reg.cfg.period};
            `ECPD_OFF_STATUS: st_next.hrdata = {st_reg.pulse_count[23:0], 2'b0,
               st_reg.pin_sync, st_reg.pending, st_reg.pulse, 1'b0, st_reg.mode};
            `ECPD_OFF_POS: st_next.hrdata = enc_pos_i;
            default: st_next.hrdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; constants only under reset
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
         st_reg.cfg.period <= `ECPD_PERIOD_RST;
         st_reg.mode <= ST_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; dedicated open-collector pin pulls low during a pulse
   assign div_pin_o = 1'b0;
   assign div_pin_oe_b_o = ~st_reg.pulse;
   assign div_pulse_o = st_reg.pulse;
   assign hrdata_o = st_reg.hrdata;
   assign hreadyout_o = 1'b1; // zero wait states
   assign hresp_o = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   int unsigned hi_cnt;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hi_cnt <= 0;
      end else begin
         hi_cnt <= st_reg.pulse ? hi_cnt + 1 : 0;
      end
   end

   pulse_width_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $fell(st_reg.pulse) |-> hi_cnt == 32'(PULSE_CYC))
      else $error("pulse width wrong");
   pulse_max_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      hi_cnt <= 32'(PULSE_CYC))
      else $error("pulse too long");
   disabled_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !st_reg.cfg.enable && !st_reg.pulse |=> !st_reg.pulse)
      else $error("pulse while disabled");
   start_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.mode == ST_ARMED && at_start && st_reg.cfg.enable
      |=> st_reg.mode == ST_RUN && st_reg.accum == 16'h0000)
      else $error("start not taken");
   stop_halt_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.mode == ST_RUN && at_stop && st_reg.cfg.enable |=> st_reg.mode == ST_DONE)
      else $error("stop not taken");
   no_run_req_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.mode != ST_RUN |=> !$rose(st_reg.pending))
      else $error("request outside run");
   divide_req_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.mode == ST_RUN && !at_stop && dir_step && st_reg.cfg.enable
      && st_reg.accum + 16'h0001 >= st_reg.cfg.period |=> st_reg.pending || st_reg.pulse)
      else $error("divide request lost");
   wrong_dir_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.mode == ST_RUN && !dir_step && !at_stop |=> $stable(st_reg.accum))
      else $error("accumulator moved");
   period_nonzero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.cfg.period != 16'h0000)
      else $error("zero period");
   held_req_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $fell(st_reg.pulse) && st_reg.pending && st_reg.cfg.enable |=> st_reg.pulse)
      else $error("held request dropped");

   ////////////////////////////////////////////////////////////////////////////
   // mode sequence, accumulator, pulse timer, pin and bus checks
   // these guard the corners that the bench never reaches:
   // a disable in mid-run, a held request, a period write while running

   // disabling drops any waiting request
   pending_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !st_reg.cfg.enable |=> !st_reg.pending)
      else $error("pending kept while disabled");
   // enable arms the divider one cycle later
   idle_arm_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.mode == ST_IDLE && st_reg.cfg.enable |=> st_reg.mode == ST_ARMED)
      else $error("enable not armed");
   // armed waits for the start position only
   armed_wait_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.mode == ST_ARMED && !at_start && st_reg.cfg.enable
      |=> st_reg.mode == ST_ARMED)
      else $error("armed left early");
   // done is left only through a disable
   done_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.mode == ST_DONE && st_reg.cfg.enable |=> st_reg.mode == ST_DONE)
      else $error("done left while enabled");
   // a counted step short of the period advances by one
   step_count_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.mode == ST_RUN && !at_stop && dir_step && st_reg.cfg.enable
      && st_reg.accum + 16'h0001 < st_reg.cfg.period |=> st_reg.accum == $past(st_reg.accum) + 16'h0001)
      else $error("step not counted");
   // every new pulse bumps the status count once
   count_bump_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(st_reg.pulse) |-> st_reg.pulse_count == $past(st_reg.pulse_count) + 32'h0000_0001)
      else $error("pulse count wrong");
   // an idle timer with a waiting request starts at once
   pulse_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !st_reg.pulse && st_reg.pending && st_reg.cfg.enable |=> st_reg.pulse)
      else $error("pulse not started");
   // open collector only ever pulls low, and only during a pulse
   pin_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      div_pin_o == 1'b0 && div_pin_oe_b_o == !div_pulse_o)
      else $error("pin drive wrong");
   // a period write lands next cycle when nonzero
   period_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      wr_go && st_reg.haddr_d == `ECPD_OFF_PERIOD && hwdata_i[15:0] != 16'h0000
      |=> st_reg.cfg.period == $past(hwdata_i[15:0]))
      else $error("period write lost");
   // read data stands only in a read data phase
   read_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !(hready_i && hsel_i && htrans_i[1] && !hwrite_i) |=> hrdata_o == 32'h0000_0000)
      else $error("stale read data");
   // bus answers at once and always okay
   bus_okay_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      hreadyout_o && !hresp_o)
      else $error("bus response wrong");

   ////////////////////////////////////////////////////////////////////////////
   // cover points for the main scenarios
   pulse_seen_c: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(st_reg.pulse));
   back_to_back_c: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      $fell(st_reg.pulse) ##1 st_reg.pulse);
   stopped_c: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.mode == ST_DONE);
   reverse_run_c: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.cfg.reverse && $rose(st_reg.pulse));
   // a request arriving while the timer is busy
   held_c: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      st_reg.pulse && st_reg.pending);

endmodule // ecpd_core

/* verification/ecpd_receiver.sv */
// Purpose: customer input stage on the divider pin
// Assumes: pull-up on the line, open collector drive
// Notes: counts pulses and pulses of the wrong width
`timescale 1ns/100ps
module ecpd_receiver #(
   parameter int WIDTH = 650
) (
   input wire logic clk_sys_i,
   input wire logic pin_o_i,
   input wire logic oe_b_i,
   output logic line_o,
   output int pulses_o,
   output int bad_o
);
   int low_cnt = 0;
   int pulses = 0;
   int bad = 0;
   // pull-up wins whenever the stage lets go
   assign line_o = oe_b_i ? 1'b1 : pin_o_i;
   assign pulses_o = pulses;
   assign bad_o = bad;
   ////////////////////////////////////////////////////////////////////////
   // width in whole cycles, judged when the line comes back up
   always @(posedge clk_sys_i) begin
      // only a real low counts; unknown before reset is not a pulse
      if (line_o === 1'b0) begin
         low_cnt <= low_cnt + 1;
      end else if (low_cnt != 0) begin
         pulses <= pulses + 1;
         if (low_cnt != WIDTH) bad <= bad + 1;
         low_cnt <= 0;
      end
   end
endmodule // ecpd_receiver

/* verification/ecpd_core_test.sv */
// Purpose: self-checking bench for the encoder count pulse divider
// Assumes: one clock, zero-wait register slave
// Notes: an integer model counts the pulses that are due
`timescale 1ns/100ps
`include "ecpd_consts.svh"
module ecpd_core_test;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] enc_pos = 32'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hreadyout, hresp, pin_o, oe_b, pulse, line;
   int pulses, bad;
   int mismatches = 0;
   int compares = 0;
   int model_cnt = 0;
   // 50 MHz
   always #10 clk = ~clk;
   ecpd_core i_ecpd_core (.clk_sys_i(clk), .rst_b_i(rst_b), .enc_pos_i(enc_pos),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
      .hresp_o(hresp), .div_pin_i(line), .div_pin_o(pin_o), .div_pin_oe_b_o(oe_b),
      .div_pulse_o(pulse));
   ecpd_receiver i_ecpd_receiver (.clk_sys_i(clk), .pin_o_i(pin_o), .oe_b_i(oe_b),
      .line_o(line), .pulses_o(pulses), .bad_o(bad));
   ////////////////////////////////////////////////////////////////////////
   // compare, count, report
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one single word transfer; waits on hready, no fixed latency assumed
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // walk the encoder past start and stop; a quarter of steps go backwards
   task automatic run(input logic rev, input int n, input int start, input logic en);
      int dir, stop, acc, gap, st, p, s;
      logic [31:0] q;
      dir = rev ? -1 : 1;
      stop = start + dir * (3 * n + n / 2 + 1);
      gap = 700 / n + 2; // keeps pulses from merging
      acc = 0;
      st = 0;
      p = start - 3 * dir;
      wr(`ECPD_OFF_CTRL, 32'h0);
      enc_pos <= p;
      wr(`ECPD_OFF_START, start);
      wr(`ECPD_OFF_STOP, stop);
      wr(`ECPD_OFF_PERIOD, n);
      wr(`ECPD_OFF_CTRL, {30'h0, rev, en});
      while (p != stop + 2 * dir) begin
         s = ($urandom % 4 == 0) ? -dir : dir;
         repeat (gap) @(posedge clk);
         p = p + s;
         enc_pos <= p;
         if (en && st == 1 && p == stop) st = 2;
         else if (en && st == 1 && s == dir && ++acc == n) begin
            model_cnt++;
            acc = 0;
         end
         if (en && st == 0 && p == start) st = 1;
      end
      repeat (700) @(posedge clk);
      check(pulses, model_cnt);
      rd(`ECPD_OFF_STATUS, q);
      check(q[31:8], model_cnt);
      check(q[1:0], en ? 2'h3 : 2'h0);
      check(bad, 0);
      check(q[5:3], 3'h4);
      check(pulse, 1'b0);
      check(hresp, 1'b0);
      rd(`ECPD_OFF_POS, q);
      check(q, enc_pos);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [31:0] q;
      void'($urandom(44606));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rd(`ECPD_OFF_PERIOD, q);
      check(q, {16'h0, `ECPD_PERIOD_RST});
      rd(`ECPD_OFF_CTRL, q);
      check(q, 32'h0);
      wr(`ECPD_OFF_PERIOD, 32'hffff);
      rd(`ECPD_OFF_PERIOD, q);
      check(q, 32'hffff);
      rd(8'h18, q);
      check(q, 32'h0);
      run(1'b0, 1, 300, 1'b1);
      run(1'b0, 2 + $urandom % 8, 400, 1'b1);
      run(1'b1, 2 + $urandom % 8, 900, 1'b1);
      run(1'b0, 3, 200, 1'b0);
      print_verdict;
   end
   // watchdog well past the longest expected run
   initial begin
      #1600000;
      mismatches++;
      print_verdict;
   end
endmodule // ecpd_core_test
